// [pwmdt_dead_time.sv]
// Dead-time inserter for one complementary output pair
`default_nettype none
module pwmdt_dead_time (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       pwm_in,
    input  wire logic       enable,
    input  wire logic       tick,
    input  wire logic [5:0] dt_count,
    output logic            out_high,
    output logic            out_low
);
    import pwmdt_pkg::*;

    logic       prev_r;
    logic [5:0] cnt_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= pwm_in;
        end
    end

    // Any edge drops both sides, then the newly high side waits out the count
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r    <= RST_DT_CNT;
            out_high <= 1'b0;
            out_low  <= 1'b0;
        end else if (!enable) begin
            cnt_r    <= RST_DT_CNT;
            out_high <= pwm_in;
            out_low  <= ~pwm_in;
        end else if (pwm_in != prev_r) begin
            cnt_r    <= dt_count;
            out_high <= 1'b0;
            out_low  <= 1'b0;
        end else if (cnt_r != RST_DT_CNT) begin
            if (tick) begin
                cnt_r <= cnt_r - 6'h01;
            end
        end else begin
            out_high <= pwm_in;
            out_low  <= ~pwm_in;
        end
    end
endmodule
`default_nettype wire

// [pwmdt_output_ctrl.sv]
// PWM output control: dead-time, centre align, break, gating, inversion, clones
`default_nettype none
module pwmdt_output_ctrl (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [3:0] sfr_page,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    input  wire logic       timer0_overflow_event,
    input  wire logic       timer1_overflow_event,
    input  wire logic       timer3_overflow_event,
    input  wire logic       serial0_timer_overflow,
    output logic            fifo_step_clock,
    input  wire logic       comparator0_out,
    input  wire logic       comparator1_out,
    input  wire logic       ext_irq1_n,
    input  wire logic       ext_irq2_n,
    input  wire logic       ext_irq3_n,
    input  wire logic       timer2_ext_input,
    input  wire logic       timer3_ext_input,
    input  wire logic       keypad_match_event,
    input  wire logic       adc_window_hit,
    input  wire logic [7:0] pwm_raw,
    input  wire logic       pwm_cycle_start,
    input  wire logic [7:0] port_latch,
    input  wire logic [1:0] clone_latch_a,
    input  wire logic [1:0] clone_latch_b,
    output logic      [7:0] module_pin,
    output logic      [1:0] clone_output_a,
    output logic      [1:0] clone_output_b,
    output logic      [7:0] center_mode,
    output logic            extended_dt_active,
    output logic            non_pwm_valid,
    output logic            break_active
);
    import pwmdt_pkg::*;

    function automatic logic src0_pick(input logic [2:0] code, input pwmdt_brk_s s);
        case (code)
            3'h1: return s.cmp0;
            3'h2: return s.irq1;
            3'h3: return s.t2ex;
            3'h4: return s.kbd;
            3'h5: return s.cmp1;
            3'h6: return s.irq3;
            3'h7: return s.adcw;
            default: return 1'b0;
        endcase
    endfunction
    function automatic logic src1_pick(input logic [1:0] code, input pwmdt_brk_s s);
        case (code)
            2'h1: return s.irq2;
            2'h2: return s.t3ex;
            2'h3: return s.kbd;
            default: return 1'b0;
        endcase
    endfunction
    function automatic logic hit(input logic [7:0] a, input logic [7:0] want);
        return sfr_wr && (a == want);
    endfunction

    pwmdt_ctrl_s  ctrl_r;
    pwmdt_dtcfg_s dtcfg_r;
    logic [7:0]   aux_flags_r;
    logic [5:0]   fifo_sel_r;
    logic [7:0]   mode_r [NUM_BRK];
    logic [7:0]   out_en_r;
    logic [7:0]   out_en_eff_r;
    logic [7:0]   clone_en_r;
    logic [7:0]   invert_r;
    logic [7:0]   pin_cfg_r;
    logic [7:0]   rd_nxt;
    logic [2:0]   presc_r;
    logic         tick;
    logic         cbc_block_r;
    logic         blocked;
    logic         brk_fire;
    logic         wr_flag;
    logic [7:0]   pwm_sel;
    logic [7:0]   sig;
    logic [NUM_PAIR-1:0] dt_on;
    logic [NUM_PAIR-1:0] dt_hi;
    logic [NUM_PAIR-1:0] dt_lo;
    logic [8:0]   brk_meta_r;
    logic [8:0]   brk_sync_r;
    pwmdt_brk_s   brk;
    // Register writes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r     <= RST_REG;
            dtcfg_r    <= RST_REG;
            fifo_sel_r <= RST_REG[5:0];
            out_en_r   <= RST_OUT_EN;
            clone_en_r <= RST_REG;
            invert_r   <= RST_REG;
            pin_cfg_r  <= RST_REG;
        end else begin
            if (hit(sfr_addr, ADDR_ALIGN_BRK) && sfr_page == PAGE_ALIGN_BRK) begin
                ctrl_r <= sfr_wdata;
            end else if (hit(sfr_addr, ADDR_DT_CFG) && sfr_page == PAGE_DT_CFG) begin
                dtcfg_r <= sfr_wdata;
            end else if (hit(sfr_addr, ADDR_FIFO_SEL) && sfr_page == PAGE_FIFO_SEL) begin
                fifo_sel_r <= sfr_wdata[5:0];
            end else if (hit(sfr_addr, ADDR_OUT_EN)) begin
                out_en_r <= sfr_wdata;
            end else if (hit(sfr_addr, ADDR_CLONE_EN)) begin
                clone_en_r <= sfr_wdata;
            end else if (hit(sfr_addr, ADDR_INVERT)) begin
                invert_r <= sfr_wdata;
            end else if (hit(sfr_addr, ADDR_PIN_CFG)) begin
                pin_cfg_r <= sfr_wdata;
            end
        end
    end
    // Module mode registers; modules 0 and 1 only on page 0
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_BRK; i++) begin
                mode_r[i] <= RST_REG;
            end
        end else begin
            for (int i = 0; i < NUM_BRK; i++) begin
                if (hit(sfr_addr, ADDR_MODE_BASE + 8'(i))
                    && (i > 1 || sfr_page == PAGE_MODE_LOW)) begin
                    mode_r[i] <= sfr_wdata;
                end
            end
        end
    end
    assign wr_flag = hit(sfr_addr, ADDR_AUX_FLAGS);
    // Auxiliary flags; the break bit is set by hardware with priority over a clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aux_flags_r <= RST_REG;
        end else begin
            if (wr_flag) begin
                aux_flags_r <= sfr_wdata;
            end
            if (brk_fire) begin
                aux_flags_r[BIT_BREAK_FLAG] <= 1'b1;
            end
        end
    end
    // Read mux
    always_comb begin
        rd_nxt = RST_REG;
        if (sfr_addr == ADDR_AUX_FLAGS) begin
            rd_nxt = aux_flags_r;
        end else if (sfr_addr == ADDR_FIFO_SEL && sfr_page == PAGE_FIFO_SEL) begin
            rd_nxt = {2'h0, fifo_sel_r} & FIFO_SEL_RD_MASK;
        end else if (sfr_addr == ADDR_ALIGN_BRK && sfr_page == PAGE_ALIGN_BRK) begin
            rd_nxt = ctrl_r;
        end else if (sfr_addr == ADDR_DT_CFG && sfr_page == PAGE_DT_CFG) begin
            rd_nxt = dtcfg_r;
        end else if (sfr_addr == ADDR_OUT_EN) begin
            rd_nxt = out_en_r;
        end else if (sfr_addr == ADDR_CLONE_EN) begin
            rd_nxt = clone_en_r;
        end else if (sfr_addr == ADDR_INVERT) begin
            rd_nxt = invert_r;
        end else if (sfr_addr == ADDR_PIN_CFG) begin
            rd_nxt = pin_cfg_r;
        end else begin
            for (int i = 0; i < NUM_BRK; i++) begin
                if (sfr_addr == ADDR_MODE_BASE + 8'(i)
                    && (i > 1 || sfr_page == PAGE_MODE_LOW)) begin
                    rd_nxt = mode_r[i];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sfr_rdata <= RST_REG;
        end else if (sfr_rd) begin
            sfr_rdata <= rd_nxt;
        end
    end
    // FIFO duty step event
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fifo_step_clock <= 1'b0;
        end else begin
            case (fifo_sel_r[FIFO_SEL_LSB +: 2])
                STEP_T0: fifo_step_clock <= timer0_overflow_event;
                STEP_T1: fifo_step_clock <= timer1_overflow_event;
                STEP_T3: fifo_step_clock <= timer3_overflow_event;
                default: fifo_step_clock <= serial0_timer_overflow;
            endcase
        end
    end
    // Break pins cross in through two flops; keypad and ADC are on this clock
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            brk_meta_r <= 9'h000;
            brk_sync_r <= 9'h000;
        end else begin
            brk_meta_r <= {comparator0_out, comparator1_out, ~ext_irq1_n, ~ext_irq2_n,
                           ~ext_irq3_n, timer2_ext_input, timer3_ext_input, 2'h0};
            brk_sync_r <= brk_meta_r;
        end
    end

    always_comb begin
        brk      = brk_sync_r;
        brk.kbd  = keypad_match_event;
        brk.adcw = adc_window_hit;
    end

    assign brk_fire = src0_pick(ctrl_r.break_source0_sel, brk)
                    | src1_pick(ctrl_r.break_source1_sel, brk);
    // Cycle-by-cycle hold released at a cycle start once the sources are quiet
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cbc_block_r <= 1'b0;
        end else if (brk_fire || (wr_flag && sfr_wdata[BIT_BREAK_FLAG])) begin
            cbc_block_r <= 1'b1;
        end else if (pwm_cycle_start) begin
            cbc_block_r <= 1'b0;
        end
    end

    assign blocked = ctrl_r.break_mode_select ? cbc_block_r
                                              : aux_flags_r[BIT_BREAK_FLAG];
    // Dead-time prescaler
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            presc_r <= RST_PRESC;
        end else begin
            presc_r <= presc_r + 3'h1;
        end
    end

    always_comb begin
        case (dtcfg_r.dead_time_prescale)
            2'h0: tick = 1'b1;
            2'h1: tick = presc_r[0];
            2'h2: tick = &presc_r[1:0];
            default: tick = &presc_r;
        endcase
    end
    // Pair dead-time units for modules 0, 2 and 4
    for (genvar p = 0; p < NUM_PAIR; p++) begin : g_pair
        assign dt_on[p] = mode_r[2*p][BIT_DTE] && pin_cfg_r[p]
                        && (dtcfg_r.dead_time_count != RST_DT_CNT);
        pwmdt_dead_time u_dt (
            .clk      (clk),
            .rstn     (rstn),
            .pwm_in   (pwm_raw[2*p]),
            .enable   (dt_on[p]),
            .tick     (tick),
            .dt_count (dtcfg_r.dead_time_count),
            .out_high (dt_hi[p]),
            .out_low  (dt_lo[p])
        );
    end
    // Channel signals; dead-time pairs take both pins of the pair
    always_comb begin
        sig = pwm_raw;
        for (int p = 0; p < NUM_PAIR; p++) begin
            if (dt_on[p]) begin
                sig[2*p]   = dt_hi[p];
                sig[2*p+1] = dt_lo[p];
            end
        end
    end
    // PWM selection per pin: mode bits for 0..5, pin config for 6 and 7
    always_comb begin
        for (int i = 0; i < NUM_BRK; i++) begin
            pwm_sel[i] = mode_r[i][BIT_ECOM] && mode_r[i][BIT_PWM];
        end
        pwm_sel[6] = pin_cfg_r[3];
        pwm_sel[7] = pin_cfg_r[4];
    end
    // Output enables applied at once or at the cycle boundary
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_en_eff_r <= RST_OUT_EN;
        end else if (!clone_en_r[BIT_TIME_ALIGN]) begin
            out_en_eff_r <= out_en_r;
        end else if (pwm_cycle_start) begin
            out_en_eff_r <= out_en_r;
        end
    end
    // Pin drive; blocked or disabled channels show the port latch
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            module_pin <= RST_REG;
        end else begin
            for (int i = 0; i < NUM_MOD; i++) begin
                if (pwm_sel[i] && out_en_eff_r[i]
                    && !(blocked && i < NUM_BRK)) begin
                    module_pin[i] <= sig[i] ^ invert_r[i];
                end else begin
                    module_pin[i] <= port_latch[i];
                end
            end
        end
    end

    // Clone outputs of modules 0 and 2
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clone_output_a <= 2'h0;
            clone_output_b <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (pwm_sel[2*c] && clone_en_r[2*c] && !blocked) begin
                    clone_output_a[c] <= pwm_raw[2*c];
                end else begin
                    clone_output_a[c] <= clone_latch_a[c];
                end
                if (pwm_sel[2*c] && clone_en_r[2*c+1] && !blocked) begin
                    clone_output_b[c] <= pwm_raw[2*c];
                end else begin
                    clone_output_b[c] <= clone_latch_b[c];
                end
            end
        end
    end

    // Status toward the counter and compare datapath
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            center_mode        <= RST_REG;
            extended_dt_active <= 1'b0;
            non_pwm_valid      <= 1'b1;
            break_active       <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_MOD; i++) begin
                center_mode[i] <= ctrl_r.center_align_enable
                                  && pwm_sel[i] && (i < NUM_BRK);
            end
            extended_dt_active <= ctrl_r.extended_dead_time;
            non_pwm_valid      <= ~ctrl_r.extended_dead_time;
            break_active       <= blocked;
        end
    end
endmodule
`default_nettype wire

// [pwmdt_pkg.sv]
// Constants, register map and carrier types for the PWM dead-time/break output block
`default_nettype none
package pwmdt_pkg;
    localparam int NUM_MOD = 8;
    localparam int NUM_BRK = 6;
    localparam int NUM_PAIR = 3;

    localparam logic [7:0] ADDR_AUX_FLAGS   = 8'hA1;
    localparam logic [7:0] ADDR_FIFO_SEL    = 8'hA4;
    localparam logic [7:0] ADDR_ALIGN_BRK   = 8'hBC;
    localparam logic [7:0] ADDR_MODE_BASE   = 8'hDA;
    localparam logic [7:0] ADDR_DT_CFG      = 8'hE6;
    localparam logic [7:0] ADDR_OUT_EN      = 8'hF2;
    localparam logic [7:0] ADDR_CLONE_EN    = 8'hF3;
    localparam logic [7:0] ADDR_INVERT      = 8'hF4;
    localparam logic [7:0] ADDR_PIN_CFG     = 8'hF5;

    localparam logic [3:0] PAGE_FIFO_SEL    = 4'h6;
    localparam logic [3:0] PAGE_ALIGN_BRK   = 4'h0;
    localparam logic [3:0] PAGE_MODE_LOW    = 4'h0;
    localparam logic [3:0] PAGE_DT_CFG      = 4'h1;

    localparam int BIT_BREAK_FLAG = 4;
    localparam int BIT_DTE        = 7;
    localparam int BIT_ECOM       = 6;
    localparam int BIT_PWM        = 1;
    localparam int BIT_TIME_ALIGN = 4;
    localparam int FIFO_SEL_LSB   = 2;
    localparam logic [7:0] FIFO_SEL_RD_MASK = 8'h3F;

    localparam logic [7:0] RST_REG    = 8'h00;
    localparam logic [7:0] RST_OUT_EN = 8'hFF;
    localparam logic [2:0] RST_PRESC  = 3'h0;
    localparam logic [5:0] RST_DT_CNT = 6'h00;

    localparam logic [1:0] STEP_T0  = 2'h0;
    localparam logic [1:0] STEP_T1  = 2'h1;
    localparam logic [1:0] STEP_T3  = 2'h2;
    localparam logic [1:0] STEP_S0  = 2'h3;

    // Control register: alignment, extension, break mode and sources
    typedef struct packed {
        logic       center_align_enable;
        logic       extended_dead_time;
        logic       break_mode_select;
        logic [1:0] break_source1_sel;
        logic [2:0] break_source0_sel;
    } pwmdt_ctrl_s;

    typedef struct packed {
        logic [1:0] dead_time_prescale;
        logic [5:0] dead_time_count;
    } pwmdt_dtcfg_s;

    // Break candidates, active high; all but kbd and adcw synchronised
    typedef struct packed {
        logic cmp0;
        logic cmp1;
        logic irq1;
        logic irq2;
        logic irq3;
        logic t2ex;
        logic t3ex;
        logic kbd;
        logic adcw;
    } pwmdt_brk_s;
endpackage
`default_nettype wire

// [pwmdt_properties.sv]
// Port-level checks for the PWM output control block
`default_nettype none
module pwmdt_properties
    import pwmdt_pkg::*;
(
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic [3:0] sfr_page,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic       timer0_overflow_event,
    input wire logic       timer1_overflow_event,
    input wire logic       timer3_overflow_event,
    input wire logic       serial0_timer_overflow,
    input wire logic       fifo_step_clock,
    input wire logic [7:0] port_latch,
    input wire logic [7:0] module_pin,
    input wire logic [7:0] center_mode,
    input wire logic       extended_dt_active,
    input wire logic       non_pwm_valid,
    input wire logic       break_active
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] ctl_r;
    logic       clr;

    // Shadow of the control register, updated by the same writes
    assign clr = sfr_wr && sfr_addr == ADDR_AUX_FLAGS && !sfr_wdata[BIT_BREAK_FLAG];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctl_r <= RST_REG;
        end else if (sfr_wr && sfr_addr == ADDR_ALIGN_BRK && sfr_page == PAGE_ALIGN_BRK) begin
            ctl_r <= sfr_wdata;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    step_cause_a: assert property (fifo_step_clock |-> $past(timer0_overflow_event
        | timer1_overflow_event | timer3_overflow_event | serial0_timer_overflow))
        else $error("fifo step without an event");
    ctrl_readback_a: assert property (sfr_rd && !sfr_wr && sfr_addr == ADDR_ALIGN_BRK
        && sfr_page == PAGE_ALIGN_BRK |=> sfr_rdata == $past(ctl_r))
        else $error("control register read mismatch");
    latched_hold_a: assert property (break_active && !ctl_r[5] && !clr && !$past(clr)
        |=> break_active)
        else $error("latched break released without clear");
    blocked_pins_a: assert property (break_active && $past(break_active)
        |-> module_pin[5:0] == $past(port_latch[5:0]))
        else $error("blocked pin not at port latch");
    flag_set_a: assert property (sfr_wr && sfr_addr == ADDR_AUX_FLAGS
        && sfr_wdata[BIT_BREAK_FLAG] |=> ##[0:2] break_active)
        else $error("software break did not block");
    center_src_a: assert property (|center_mode[5:0] |-> $past(ctl_r[7]))
        else $error("centre mode without enable");
    center_hi_a: assert property (center_mode[7:6] == 2'b00)
        else $error("modules 6 or 7 centre aligned");
    ext_follow_a: assert property (extended_dt_active == $past(ctl_r[6]))
        else $error("extension flag does not follow control");
    nonpwm_a: assert property (non_pwm_valid != extended_dt_active)
        else $error("non-pwm valid not inverse of extension");
endmodule
`default_nettype wire

// [pwmdt_stage.sv]
// Power stage model: overcurrent comparator and shoot-through watch on pair 0
`default_nettype none
module pwmdt_stage (
    input  wire logic       clk,
    input  wire logic [1:0] gate,
    input  wire logic       trip,
    output logic            oc_out,
    output logic            overlap
);
    timeunit 1ns;
    timeprecision 100ps;
    initial overlap = 1'b0;
    initial oc_out = 1'b0;

    always @(posedge clk) begin
        oc_out <= trip;
        if (gate == 2'b11) begin
            overlap <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// [tb_pwm_deadtime_break_output_control.sv]
// Self-checking bench for the PWM output control block
`default_nettype none
module tb_pwm_deadtime_break_output_control
    import pwmdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  sfr_page = 4'h0;
    logic [7:0]  sfr_addr = 8'h00;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        sfr_wr = 1'b0;
    logic        sfr_rd = 1'b0;
    logic [3:0]  ev = 4'h0;
    logic [8:0]  brk = 9'h000;
    logic [7:0]  pwm_raw = 8'hFF;
    logic        pwm_cycle_start = 1'b0;
    logic [7:0]  port_latch = 8'h00;
    logic [7:0]  sfr_rdata, module_pin, center_mode;
    logic        fifo_step_clock, extended_dt_active, non_pwm_valid, break_active;
    logic        cmp0, overlap;
    logic [1:0]  clat = 2'b10;
    logic [1:0]  cla, clb;
    logic [15:0] dtab [4] = '{16'h0143, 16'h01C2, 16'h0100, 16'h0043};
    int          fail_count = 0;
    int          cmp_count = 0;
    int          n, d, i;

    always #2 clk = ~clk;

    pwmdt_output_ctrl dut (
        .clk, .rstn, .sfr_page, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
        .timer0_overflow_event(ev[0]), .timer1_overflow_event(ev[1]),
        .timer3_overflow_event(ev[2]), .serial0_timer_overflow(ev[3]),
        .fifo_step_clock, .comparator0_out(cmp0), .comparator1_out(brk[4]),
        .ext_irq1_n(~brk[1]), .ext_irq2_n(~brk[7]), .ext_irq3_n(~brk[5]),
        .timer2_ext_input(brk[2]), .timer3_ext_input(brk[8]),
        .keypad_match_event(brk[3]), .adc_window_hit(brk[6]),
        .pwm_raw, .pwm_cycle_start, .port_latch, .clone_latch_a(clat),
        .clone_latch_b(clat), .module_pin, .clone_output_a(cla), .clone_output_b(clb),
        .center_mode, .extended_dt_active, .non_pwm_valid, .break_active
    );

    pwmdt_stage stage (.clk, .gate(module_pin[1:0]), .trip(brk[0]), .oc_out(cmp0), .overlap);

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] v);
        cyc(1);
        sfr_page = pg;
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1'b1;
        cyc(1);
        sfr_wr = 1'b0;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rchk(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] e);
        cyc(1);
        sfr_page = pg;
        sfr_addr = a;
        sfr_rd = 1'b1;
        cyc(1);
        sfr_rd = 1'b0;
        chk("register", e, sfr_rdata);
    endtask

    task automatic tick_cycle();
        pwm_cycle_start = 1'b1;
        cyc(1);
        pwm_cycle_start = 1'b0;
        cyc(3);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fail_count++;
        finish_test();
    end

    initial begin
        cyc(16);
        rstn = 1'b1;
        rchk(4'h0, ADDR_AUX_FLAGS, RST_REG);
        rchk(PAGE_FIFO_SEL, ADDR_FIFO_SEL, RST_REG);
        rchk(4'h0, ADDR_ALIGN_BRK, RST_REG);
        rchk(4'h0, ADDR_MODE_BASE, RST_REG);
        rchk(PAGE_DT_CFG, ADDR_DT_CFG, RST_REG);
        rchk(4'h0, ADDR_OUT_EN, RST_OUT_EN);
        rchk(4'h0, 8'h00, 8'h00);
        for (int s = 0; s < 4; s++) begin
            wr(PAGE_FIFO_SEL, ADDR_FIFO_SEL, 8'(s << FIFO_SEL_LSB));
            for (int e = 0; e < 4; e++) begin
                ev = 4'(1 << e);
                cyc(1);
                ev = 4'h0;
                chk("fifo_step", 8'(s == e), 8'(fifo_step_clock));
            end
        end
        wr(4'h0, ADDR_FIFO_SEL, 8'h00);
        rchk(PAGE_FIFO_SEL, ADDR_FIFO_SEL, 8'h0C);
        wr(PAGE_FIFO_SEL, ADDR_FIFO_SEL, 8'hFF);
        rchk(PAGE_FIFO_SEL, ADDR_FIFO_SEL, FIFO_SEL_RD_MASK);
        wr(4'h0, ADDR_MODE_BASE + 8'h01, 8'h42);
        wr(4'h0, ADDR_PIN_CFG, 8'h08);
        cyc(3);
        chk("pins", 8'h42, module_pin);
        wr(4'h0, ADDR_AUX_FLAGS, 8'h10);
        cyc(2);
        chk("pins", 8'h40, module_pin);
        rchk(4'h0, ADDR_AUX_FLAGS, 8'h10);
        tick_cycle();
        chk("break", 8'h01, 8'(break_active));
        wr(4'h0, ADDR_AUX_FLAGS, 8'h00);
        cyc(3);
        chk("pins", 8'h42, module_pin);
        wr(4'h0, ADDR_INVERT, 8'h02);
        wr(4'h0, ADDR_OUT_EN, 8'hBF);
        cyc(3);
        chk("pins", 8'h00, module_pin);
        wr(4'h0, ADDR_INVERT, 8'h00);
        wr(4'h0, ADDR_OUT_EN, 8'hFF);
        wr(4'h0, ADDR_CLONE_EN, 8'h10);
        wr(4'h0, ADDR_OUT_EN, 8'hFD);
        cyc(3);
        chk("pins", 8'h42, module_pin);
        tick_cycle();
        chk("pins", 8'h40, module_pin);
        wr(4'h0, ADDR_CLONE_EN, 8'h00);
        wr(4'h0, ADDR_OUT_EN, 8'hFF);
        wr(4'h0, ADDR_ALIGN_BRK, 8'h21);
        brk[0] = 1'b1;
        cyc(5);
        brk[0] = 1'b0;
        cyc(5);
        chk("break", 8'h01, 8'(break_active));
        tick_cycle();
        chk("break", 8'h00, 8'(break_active));
        rchk(4'h0, ADDR_AUX_FLAGS, 8'h10);
        wr(4'h0, ADDR_AUX_FLAGS, 8'h00);
        // Codes 1..7 walk source 0, codes 8..10 walk source 1
        for (int c = 1; c < 11; c++) begin
            i = (c == 10) ? 3 : c - 1;
            wr(4'h0, ADDR_ALIGN_BRK, (c < 8) ? 8'(c) : 8'((c - 7) << 3));
            cyc(4);
            chk("break", 8'h00, 8'(break_active));
            brk[i] = 1'b1;
            cyc(6);
            chk("break", 8'h01, 8'(break_active));
            brk[i] = 1'b0;
            cyc(4);
            wr(4'h0, ADDR_AUX_FLAGS, 8'h00);
            cyc(3);
            chk("break", 8'h00, 8'(break_active));
        end
        wr(4'h0, ADDR_ALIGN_BRK, 8'hC0);
        cyc(3);
        chk("center", 8'h02, center_mode);
        chk("ext", 8'h01, 8'(extended_dt_active));
        chk("nonpwm", 8'h00, 8'(non_pwm_valid));
        wr(4'h0, ADDR_ALIGN_BRK, 8'h00);
        wr(4'h0, ADDR_MODE_BASE, 8'hC2);
        pwm_raw = 8'h00;
        for (int k = 0; k < 4; k++) begin
            wr(4'h0, ADDR_PIN_CFG, dtab[k][15:8]);
            wr(PAGE_DT_CFG, ADDR_DT_CFG, dtab[k][7:0]);
            cyc(40);
            pwm_raw[0] = 1'b1;
            n = 0;
            while (module_pin[0] !== 1'b1 && n < 200) begin
                cyc(1);
                n++;
            end
            d = dtab[k][8] ? int'(dtab[k][5:0]) << dtab[k][7:6] : 0;
            chk("dt_min", 8'h01, 8'(n >= d - (1 << dtab[k][7:6]) + 1));
            chk("dt_max", 8'h01, 8'(n <= d + 3));
            pwm_raw[0] = 1'b0;
        end
        cyc(40);
        chk("overlap", 8'h00, 8'(overlap));
        // Module 0 raw high, clone a of module 0 on; module 2 not in PWM
        pwm_raw = 8'h01;
        wr(4'h0, ADDR_CLONE_EN, 8'h01);
        cyc(3);
        chk("clone_a", 8'h03, 8'(cla));
        chk("clone_b", 8'h02, 8'(clb));
        wr(4'h0, ADDR_AUX_FLAGS, 8'h10);
        cyc(3);
        chk("clone_a", 8'h02, 8'(cla));
        finish_test();
    end
endmodule

bind pwmdt_output_ctrl pwmdt_properties u_props (
    .clk, .rstn, .sfr_page, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
    .timer0_overflow_event, .timer1_overflow_event, .timer3_overflow_event,
    .serial0_timer_overflow, .fifo_step_clock, .port_latch, .module_pin,
    .center_mode, .extended_dt_active, .non_pwm_valid, .break_active
);
`default_nettype wire
